// *** design/rts_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RTS_CFG_SVH
`define RTS_CFG_SVH

`define RTS_PWRUP_TIME_US 72000
`define RTS_BO_QUAL_TIME_US 100
`define RTS_OSC_START_CYCLES 1024
`define RTS_REF_KHZ_DEF 1000

`define RTS_OFF_PCTRL 8'h00
`define RTS_OFF_FLAGS 8'h04
`define RTS_OFF_IRQ_STS 8'h08
`define RTS_OFF_IRQ_MSK 8'h0C

`define RTS_PCS_BO_BIT 0
`define RTS_PCS_PON_BIT 1
`define RTS_FLAG_TIMEOUT_BIT 4
`define RTS_FLAG_PWRDN_BIT 3

`define RTS_IRQ_PON 0
`define RTS_IRQ_BO 1
`define RTS_IRQ_WDOG 2
`define RTS_IRQ_WAKE 3
`define RTS_IRQ_MCLEAR 4

`define RTS_PCS_RST 2'h0
`define RTS_IRQ_RST 5'h00
`define RTS_VEC_RESET 13'h0000
`define RTS_VEC_IRQ 13'h0004

`endif

// *** design/rts_pkg.sv ***
// Types of the reset sequencer
`default_nettype none
package rts_pkg;
  typedef enum logic [1:0] {
    OSC_LOW_POWER_XTAL,
    OSC_XTAL,
    OSC_HS_XTAL,
    OSC_RES_CAP
  } rts_osc_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_BROWNOUT,
    ST_PWRUP_DLY,
    ST_OSC_START,
    ST_HOLD
  } rts_fsm_t;

  typedef struct packed {
    rts_fsm_t st;
    logic [23:0] cnt;
    logic [23:0] bo_cnt;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] stab;
    logic wake;
    logic to_n;
    logic pd_n;
    logic [1:0] power_control_status;
    logic rst_o;
    logic hold_o;
    logic pc_load;
    logic [12:0] pc_val;
    logic [4:0] irq_sts;
    logic [4:0] irq_msk;
    logic irq_o;
    logic a_vld;
    logic a_wr;
    logic a_hit;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } rts_state_t;
endpackage
`default_nettype wire

// *** design/rts_top.sv ***
// Reset and time-out sequencer with AHB-Lite status registers
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rts_cfg.svh"

// Behaviour
// - Brown-out detection causes reset only when the enable fuse is set.
// - Supply low longer than the qualify time forces brown-out reset.
// - Hold reset while supply low, then run the power-up delay.
// - Supply dropping again during the delay restarts the brown-out sequence.
// - Brown-out enable forces the power-up delay on regardless of its off fuse.
// - Power-on runs delay if enabled, then 1024 oscillator cycles in crystal modes.
// - Clear pin held low past all time-outs starts execution on release.
// - Crystal: delay plus 1024 cycles; wake 1024 cycles; RC: delay only, no wake delay.
// - Bit 0 active-low brown-out flag, cleared by brown-out; software sets it.
// - Bit 1 cleared by power-on only; software sets it afterwards.
// - Brown-out flag carries no meaning while brown-out reset is disabled.
// - Timeout and power-down flags take fixed values per reset or wake cause; master clear while awake leaves them unchanged.
// - Resets load PC 000h; wake continues PC+1, or 0004h on enabled interrupt.
// - Power-on loads flags 1,1; other causes touch only their own flags.
// - Unimplemented bits read zero; unchanged bits keep their value.
// - Oscillator start count only in crystal modes after power-on, brown-out or wake.
// - Watchdog reset stays internal and never drives the clear pin.
module rts_top #(
  parameter int unsigned REF_KHZ = `RTS_REF_KHZ_DEF,
  parameter int unsigned PWRUP_TICKS = (`RTS_PWRUP_TIME_US * REF_KHZ + 999) / 1000,
  parameter int unsigned BO_QUAL_TICKS = (`RTS_BO_QUAL_TIME_US * REF_KHZ + 999) / 1000
) (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic POWER_ON_IN,
  input wire logic BROWNOUT_LOW_IN,
  input wire logic MASTER_CLEAR_N_IN,
  input wire logic REF_CLK_IN,
  input wire logic WATCHDOG_EVENT_IN,
  input wire logic SLEEP_IN,
  input wire logic IRQ_WAKE_IN,
  input wire logic GLOBAL_IRQ_ENABLE_IN,
  input wire logic [12:0] PC_IN,
  input wire logic BROWNOUT_ENABLE_FUSE_IN,
  input wire logic POWERUP_DELAY_OFF_IN,
  input wire rts_pkg::rts_osc_t OSC_MODE_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic CORE_RESET_OUT,
  output logic CORE_HOLD_OUT,
  output logic PC_LOAD_OUT,
  output logic [12:0] PC_VALUE_OUT,
  output logic TIMEOUT_FLAG_N_OUT,
  output logic POWERDOWN_FLAG_N_OUT,
  output logic IRQ_OUT
);
  import rts_pkg::*;

  localparam int unsigned SY_REF = 0;
  localparam int unsigned SY_MCLEAR = 1;
  localparam int unsigned SY_BO = 2;
  localparam int unsigned SY_PON = 3;
  localparam int unsigned OSC_LAST = `RTS_OSC_START_CYCLES - 1;

  rts_state_t state_q;
  rts_state_t state_d;

  logic ref_tick;
  logic master_clear_n_hi;
  logic bo_low;
  logic pon;
  logic bo_qual;
  logic crystal;
  logic pwr_en;

  function automatic logic cnt_last(input logic [23:0] c, input int unsigned lim);
    cnt_last = (c == 24'(lim - 1));
  endfunction

  function automatic rts_state_t reset_val();
    rts_state_t r;
    r = '0;
    r.st = ST_HOLD;
    r.to_n = 1'b1;
    r.pd_n = 1'b1;
    r.power_control_status = `RTS_PCS_RST;
    r.rst_o = 1'b1;
    r.hold_o = 1'b1;
    r.pc_val = `RTS_VEC_RESET;
    r.irq_sts = `RTS_IRQ_RST;
    r.irq_msk = `RTS_IRQ_RST;
    r.hready = 1'b1;
    r.s1 = 4'h2;
    r.s2 = 4'h2;
    r.s3 = 4'h2;
    r.stab = 4'h2;
    return r;
  endfunction

  always_comb begin
    state_d = state_q;
    state_d.pc_load = 1'b0;
    state_d.s1 = {POWER_ON_IN, BROWNOUT_LOW_IN, MASTER_CLEAR_N_IN, REF_CLK_IN};
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    for (int i = 0; i < 4; i++) begin
      if (state_q.s2[i] == state_q.s3[i]) begin
        state_d.stab[i] = state_q.s3[i];
      end
    end
    // reference clock edge as time base
    ref_tick = state_d.stab[SY_REF] & ~state_q.stab[SY_REF];
    master_clear_n_hi = state_q.stab[SY_MCLEAR];
    bo_low = state_q.stab[SY_BO] & BROWNOUT_ENABLE_FUSE_IN;
    pon = state_q.stab[SY_PON];
    crystal = (OSC_MODE_IN != OSC_RES_CAP);
    pwr_en = ~POWERUP_DELAY_OFF_IN | BROWNOUT_ENABLE_FUSE_IN;

    bo_qual = bo_low && (state_q.bo_cnt == 24'(BO_QUAL_TICKS));
    if (!bo_low) begin
      state_d.bo_cnt = 24'h0;
    end else if (ref_tick && !bo_qual) begin
      state_d.bo_cnt = state_q.bo_cnt + 24'h1;
    end

    // Bus writes first so that hardware events below win
    if (state_q.a_vld && state_q.a_wr && state_q.a_hit) begin
      unique case (state_q.a_addr)
        `RTS_OFF_PCTRL: state_d.power_control_status = HWDATA_IN[1:0];
        `RTS_OFF_IRQ_STS: state_d.irq_sts = state_q.irq_sts & ~HWDATA_IN[4:0];
        `RTS_OFF_IRQ_MSK: state_d.irq_msk = HWDATA_IN[4:0];
        default: state_d.power_control_status = state_d.power_control_status;
      endcase
    end

    if (pon) begin
      // power-on restarts the chain while the pulse stands
      state_d.to_n = 1'b1;
      state_d.pd_n = 1'b1;
      state_d.power_control_status[`RTS_PCS_PON_BIT] = 1'b0;
      state_d.irq_sts[`RTS_IRQ_PON] = 1'b1;
      state_d.wake = 1'b0;
      state_d.cnt = 24'h0;
      // time-out chain chosen by mode and fuse
      if (pwr_en) begin
        state_d.st = ST_PWRUP_DLY;
      end else if (crystal) begin
        state_d.st = ST_OSC_START;
      end else begin
        state_d.st = ST_HOLD;
      end
    end else if (bo_qual && state_q.st != ST_BROWNOUT) begin
      state_d.st = ST_BROWNOUT;
      state_d.to_n = 1'b1;
      state_d.pd_n = 1'b1;
      state_d.power_control_status[`RTS_PCS_BO_BIT] = 1'b0;
      state_d.irq_sts[`RTS_IRQ_BO] = 1'b1;
      state_d.wake = 1'b0;
    end else begin
      unique case (state_q.st)
        ST_RUN: begin
          if (!master_clear_n_hi) begin
            state_d.st = ST_HOLD;
            state_d.irq_sts[`RTS_IRQ_MCLEAR] = 1'b1;
            if (SLEEP_IN) begin
              state_d.to_n = 1'b1;
              state_d.pd_n = 1'b0;
            end
          end else if (WATCHDOG_EVENT_IN || (SLEEP_IN && IRQ_WAKE_IN)) begin
            if (WATCHDOG_EVENT_IN && !SLEEP_IN) begin
              state_d.st = ST_HOLD;
              state_d.to_n = 1'b0;
              state_d.pd_n = 1'b1;
              state_d.irq_sts[`RTS_IRQ_WDOG] = 1'b1;
            end else begin
              state_d.to_n = ~WATCHDOG_EVENT_IN;
              state_d.pd_n = 1'b0;
              state_d.irq_sts[`RTS_IRQ_WAKE] = 1'b1;
              if (!WATCHDOG_EVENT_IN && GLOBAL_IRQ_ENABLE_IN) begin
                state_d.pc_val = `RTS_VEC_IRQ;
              end else begin
                state_d.pc_val = 13'(PC_IN + 13'h0001);
              end
              // start count on wake only in crystal modes
              if (crystal) begin
                state_d.st = ST_OSC_START;
                state_d.wake = 1'b1;
                state_d.cnt = 24'h0;
              end else begin
                state_d.pc_load = 1'b1;
              end
            end
          end
        end
        ST_BROWNOUT: begin
          if (!bo_low) begin
            state_d.st = ST_PWRUP_DLY;
            state_d.cnt = 24'h0;
          end
        end
        ST_PWRUP_DLY: begin
          if (bo_low) begin
            state_d.st = ST_BROWNOUT;
            state_d.power_control_status[`RTS_PCS_BO_BIT] = 1'b0;
          end else if (ref_tick) begin
            if (cnt_last(state_q.cnt, PWRUP_TICKS)) begin
              state_d.cnt = 24'h0;
              state_d.st = crystal ? ST_OSC_START : ST_HOLD;
            end else begin
              state_d.cnt = state_q.cnt + 24'h1;
            end
          end
        end
        ST_OSC_START: begin
          if (state_q.wake && !master_clear_n_hi) begin
            state_d.st = ST_HOLD;
            state_d.wake = 1'b0;
            state_d.to_n = 1'b1;
            state_d.pd_n = 1'b0;
            state_d.irq_sts[`RTS_IRQ_MCLEAR] = 1'b1;
          end else if (cnt_last(state_q.cnt, OSC_LAST + 1)) begin
            state_d.cnt = 24'h0;
            state_d.wake = 1'b0;
            if (state_q.wake) begin
              state_d.st = ST_RUN;
              state_d.pc_load = 1'b1;
            end else begin
              state_d.st = ST_HOLD;
            end
          end else begin
            state_d.cnt = state_q.cnt + 24'h1;
          end
        end
        ST_HOLD: begin
          if (master_clear_n_hi) begin
            state_d.st = ST_RUN;
            state_d.pc_load = 1'b1;
            state_d.pc_val = `RTS_VEC_RESET;
          end
        end
      endcase
    end

    state_d.rst_o = (state_d.st != ST_RUN) && !state_d.wake;
    state_d.hold_o = (state_d.st != ST_RUN);
    state_d.irq_o = |(state_d.irq_sts & state_d.irq_msk);

    // AHB-Lite address phase, zero wait states
    state_d.a_vld = HSEL_IN && HTRANS_IN[1] && HREADY_IN && (HSIZE_IN == 3'h2);
    state_d.a_wr = HWRITE_IN;
    state_d.a_hit = (HADDR_IN[31:8] == 24'h0) && (HADDR_IN[1:0] == 2'h0);
    state_d.a_addr = HADDR_IN[7:0];
    state_d.hready = 1'b1;
    state_d.hresp = 1'b0;
    state_d.hrdata = 32'h0;
    if (state_d.a_vld && !state_d.a_wr && state_d.a_hit) begin
      unique case (state_d.a_addr)
        `RTS_OFF_PCTRL: state_d.hrdata = {30'h0, state_d.power_control_status};
        `RTS_OFF_FLAGS: begin
          state_d.hrdata[`RTS_FLAG_TIMEOUT_BIT] = state_d.to_n;
          state_d.hrdata[`RTS_FLAG_PWRDN_BIT] = state_d.pd_n;
        end
        `RTS_OFF_IRQ_STS: state_d.hrdata = {27'h0, state_d.irq_sts};
        `RTS_OFF_IRQ_MSK: state_d.hrdata = {27'h0, state_d.irq_msk};
        default: state_d.hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state_q <= reset_val();
    end else begin
      state_q <= state_d;
    end
  end

  assign HRDATA_OUT = state_q.hrdata;
  assign HREADYOUT_OUT = state_q.hready;
  assign HRESP_OUT = state_q.hresp;
  assign CORE_RESET_OUT = state_q.rst_o;
  assign CORE_HOLD_OUT = state_q.hold_o;
  assign PC_LOAD_OUT = state_q.pc_load;
  assign PC_VALUE_OUT = state_q.pc_val;
  assign TIMEOUT_FLAG_N_OUT = state_q.to_n;
  assign POWERDOWN_FLAG_N_OUT = state_q.pd_n;
  assign IRQ_OUT = state_q.irq_o;

  property p_bo_off;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (!BROWNOUT_ENABLE_FUSE_IN && state_q.st != ST_BROWNOUT) |=> state_q.st != ST_BROWNOUT;
  endproperty
  a_bo_off: assert property (p_bo_off) else $error("brown-out entered while disabled");

  property p_bo_qual;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (bo_low && state_q.bo_cnt == 24'(BO_QUAL_TICKS) && !pon && state_q.st != ST_BROWNOUT)
      |=> (state_q.st == ST_BROWNOUT && CORE_RESET_OUT);
  endproperty
  a_bo_qual: assert property (p_bo_qual) else $error("qualified dip gave no reset");

  property p_bo_recover;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_q.st == ST_BROWNOUT && !bo_low && !pon) |=> state_q.st == ST_PWRUP_DLY;
  endproperty
  a_bo_recover: assert property (p_bo_recover) else $error("no delay after recovery");

  property p_bo_restart;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_q.st == ST_PWRUP_DLY && bo_low && !pon) |=> state_q.st == ST_BROWNOUT;
  endproperty
  a_bo_restart: assert property (p_bo_restart) else $error("delay not abandoned");

  property p_pwr_forced;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (pon && BROWNOUT_ENABLE_FUSE_IN) |=> state_q.st == ST_PWRUP_DLY;
  endproperty
  a_pwr_forced: assert property (p_pwr_forced) else $error("delay not forced on");

  property p_osc_end;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_q.st == ST_OSC_START && state_q.cnt == 24'(OSC_LAST)) |=> state_q.st != ST_OSC_START;
  endproperty
  a_osc_end: assert property (p_osc_end) else $error("start count overran");

  property p_release;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_q.st == ST_HOLD && master_clear_n_hi && !pon && !bo_qual)
      |=> (state_q.st == ST_RUN && PC_LOAD_OUT && PC_VALUE_OUT == 13'h0000) ##1 !CORE_RESET_OUT;
  endproperty
  a_release: assert property (p_release) else $error("no start on pin release");

  property p_rc_nodelay;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (pon && POWERUP_DELAY_OFF_IN && !BROWNOUT_ENABLE_FUSE_IN && OSC_MODE_IN == OSC_RES_CAP)
      |=> state_q.st == ST_HOLD;
  endproperty
  a_rc_nodelay: assert property (p_rc_nodelay) else $error("RC mode ran a delay");

  property p_bo_flag;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_q.st != ST_BROWNOUT ##1 state_q.st == ST_BROWNOUT) |-> !state_q.power_control_status[`RTS_PCS_BO_BIT];
  endproperty
  a_bo_flag: assert property (p_bo_flag) else $error("brown-out flag not cleared");

  property p_pon_flag;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      pon |=> (!state_q.power_control_status[`RTS_PCS_PON_BIT] && TIMEOUT_FLAG_N_OUT && POWERDOWN_FLAG_N_OUT);
  endproperty
  a_pon_flag: assert property (p_pon_flag) else $error("power-on flags wrong");

  property p_wdog_flags;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_q.st == ST_RUN && master_clear_n_hi && WATCHDOG_EVENT_IN && !SLEEP_IN && !pon && !bo_qual)
      |=> (!TIMEOUT_FLAG_N_OUT && POWERDOWN_FLAG_N_OUT && CORE_RESET_OUT);
  endproperty
  a_wdog_flags: assert property (p_wdog_flags) else $error("watchdog flags wrong");

  property p_irq_vec;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_q.st == ST_RUN && master_clear_n_hi && !WATCHDOG_EVENT_IN && SLEEP_IN && IRQ_WAKE_IN &&
       GLOBAL_IRQ_ENABLE_IN && OSC_MODE_IN == OSC_RES_CAP && !pon && !bo_qual)
      |=> (PC_LOAD_OUT && PC_VALUE_OUT == 13'h0004);
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector not loaded");

  property p_zero_bits;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      state_q.a_vld |-> HRDATA_OUT[31:8] == 24'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits not zero");

  property p_osc_mode;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_q.st != ST_OSC_START ##1 state_q.st == ST_OSC_START)
      |-> $past(OSC_MODE_IN) != OSC_RES_CAP;
  endproperty
  a_osc_mode: assert property (p_osc_mode) else $error("start count in RC mode");
endmodule
`default_nettype wire

// *** testbench/rts_supply_model.sv ***
// Supply comparators, clear pin and reference oscillator beside the sequencer
`timescale 1ns/1ns
`default_nettype none
module rts_supply_model (
  input wire logic clk_in,
  input wire logic pon_req_in,
  input wire logic vdd_low_in,
  input wire logic clr_low_in,
  output logic power_on_out,
  output logic brownout_low_out,
  output logic master_clear_n_out,
  output logic ref_clk_out
);
  logic [2:0] div_q = 3'h0;
  always @(posedge clk_in) begin
    div_q <= div_q + 3'h1;
  end
  // Eight oscillator cycles per reference tick
  assign ref_clk_out = div_q[2];
  assign brownout_low_out = vdd_low_in;
  assign power_on_out = pon_req_in;
  // pin held low as long as asked
  assign master_clear_n_out = ~clr_low_in;
endmodule
`default_nettype wire

// *** testbench/test_rts_top.sv ***
// Self-checking bench of the reset sequencer
`timescale 1ns/1ns
`default_nettype none
module test_rts_top;
  import rts_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pon_req = 1'b1, vdd_low = 1'b0, clr_low = 1'b0;
  logic pon, bo_low, clr_n, ref_clk;
  logic wdog = 1'b0, sleep = 1'b0, wake = 1'b0, irq_en = 1'b0;
  logic fuse_bo = 1'b1;
  rts_osc_t osc_mode = OSC_XTAL;
  logic [12:0] pc = 13'h0000;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic hreadyout, hresp, core_rst, core_hold, pc_load, flag_t_n, flag_p_n, irq;
  logic [12:0] pc_val;
  int mismatches = 0, comparisons = 0, n;

  rts_supply_model i_supply (.clk_in(clk), .pon_req_in(pon_req), .vdd_low_in(vdd_low),
    .clr_low_in(clr_low), .power_on_out(pon), .brownout_low_out(bo_low),
    .master_clear_n_out(clr_n), .ref_clk_out(ref_clk));

  rts_top #(.PWRUP_TICKS(10), .BO_QUAL_TICKS(3)) i_dut (.CLOCK_IN(clk), .RST_IN(rst),
    .POWER_ON_IN(pon), .BROWNOUT_LOW_IN(bo_low), .MASTER_CLEAR_N_IN(clr_n),
    .REF_CLK_IN(ref_clk), .WATCHDOG_EVENT_IN(wdog), .SLEEP_IN(sleep), .IRQ_WAKE_IN(wake),
    .GLOBAL_IRQ_ENABLE_IN(irq_en), .PC_IN(pc), .BROWNOUT_ENABLE_FUSE_IN(fuse_bo),
    .POWERUP_DELAY_OFF_IN(1'b1), .OSC_MODE_IN(osc_mode), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp),
    .CORE_RESET_OUT(core_rst), .CORE_HOLD_OUT(core_hold), .PC_LOAD_OUT(pc_load),
    .PC_VALUE_OUT(pc_val), .TIMEOUT_FLAG_N_OUT(flag_t_n), .POWERDOWN_FLAG_N_OUT(flag_p_n),
    .IRQ_OUT(irq));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Cycle count checked as in-window flag
  task automatic chk_rng(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        mismatches++;
        report_and_stop();
      end
      @(posedge clk);
    end
  endtask

  // Single word transfer, read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wait_load(input int maxc);
    n = 0;
    while (pc_load !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > maxc) begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Early release from hold state is ignored here
    repeat (10) @(posedge clk);
    pon_req <= 1'b0;
    wait_load(3000);
    chk_rng(1096, 1150);
    chk({flag_t_n, flag_p_n, pc_val}, {2'b11, 13'h0000});
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk(rd & 32'hFFFFFFFE, 32'h0);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk(rd, 32'h18);
    ahb(1'b1, 32'h4, 32'h0, rd);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk(rd, 32'h18);
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h0, 32'h3, rd);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h3);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk(rd & 32'h1, 32'h1);
    chk(irq, 1'b0);
    ahb(1'b1, 32'hC, 32'h1, rd);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    ahb(1'b1, 32'h8, 32'h1F, rd);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk(rd, 32'h0);
    // Watchdog reset while running
    @(posedge clk);
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    wait_load(50);
    chk({flag_t_n, flag_p_n, pc_val}, {2'b01, 13'h0000});
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h3);
    // Clear pin held low for 200 cycles while running, with no time-out count involved
    @(posedge clk);
    clr_low <= 1'b1;
    repeat (200) @(posedge clk);
    chk(core_rst, 1'b1);
    clr_low <= 1'b0;
    wait_load(20);
    chk({flag_t_n, flag_p_n, pc_val}, {2'b01, 13'h0000});
    // Short dip, then a real brown-out that recurs mid-delay
    @(posedge clk);
    vdd_low <= 1'b1;
    @(posedge clk);
    vdd_low <= 1'b0;
    repeat (40) @(posedge clk);
    chk(core_rst, 1'b0);
    vdd_low <= 1'b1;
    repeat (60) @(posedge clk);
    chk(core_rst, 1'b1);
    vdd_low <= 1'b0;
    repeat (30) @(posedge clk);
    vdd_low <= 1'b1;
    repeat (40) @(posedge clk);
    chk(core_rst, 1'b1);
    vdd_low <= 1'b0;
    wait_load(3000);
    chk_rng(1096, 1150);
    chk({flag_t_n, flag_p_n, pc_val}, {2'b11, 13'h0000});
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h2);
    // Wake-ups: watchdog, interrupt with and without global enable
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      sleep <= 1'b1;
      irq_en <= (k == 1);
      pc <= 13'h0123 + 13'(k);
      @(posedge clk);
      wdog <= (k == 0);
      wake <= (k != 0);
      @(posedge clk);
      wdog <= 1'b0;
      wake <= 1'b0;
      repeat (4) @(posedge clk);
      // Core stalled but out of reset during wake count
      chk({core_rst, core_hold}, 2'b01);
      wait_load(1200);
      sleep <= 1'b0;
      chk_rng(1015, 1035);
      chk(pc_val, (k == 1) ? 13'h0004 : 13'h0124 + 13'(k));
      chk({flag_t_n, flag_p_n}, (k == 0) ? 2'b00 : 2'b10);
    end
    // Brown-out fuse off and RC oscillator: no brown-out, no wake delay
    @(posedge clk);
    fuse_bo <= 1'b0;
    osc_mode <= OSC_RES_CAP;
    vdd_low <= 1'b1;
    repeat (60) @(posedge clk);
    chk(core_rst, 1'b0);
    vdd_low <= 1'b0;
    sleep <= 1'b1;
    irq_en <= 1'b1;
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_load(4);
    sleep <= 1'b0;
    chk_rng(1, 2);
    chk({core_rst, pc_val}, {1'b0, 13'h0004});
    chk({flag_t_n, flag_p_n}, 2'b10);
    // Power-on in RC mode with both fuses off: no delay at all
    pon_req <= 1'b1;
    repeat (10) @(posedge clk);
    pon_req <= 1'b0;
    wait_load(40);
    chk_rng(5, 8);
    chk({flag_t_n, flag_p_n}, 2'b11);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h0);
    // Logic reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({core_rst, core_hold, pc_load, flag_t_n, flag_p_n, irq, hreadyout, hresp}, 8'hDA);
    rst <= 1'b0;
    wait_load(10);
    chk(pc_val, 13'h0000);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
